// *** hw/mear_ahb_front.sv ***
`timescale 1ns/1ps
`include "mear_defines.svh"
module mear_ahb_front
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             ap_valid,
  output logic             ap_write,
  output logic [7:0]       ap_idx,
  output logic             dp_wr,
  output logic [7:0]       dp_idx
);
  import mear_pkg::*;

  typedef struct packed
  {
    logic       wr;
    logic [7:0] idx;
  } mear_front_t;

  mear_front_t st_r;
  mear_front_t st_nxt;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  // only nonseq singles are taken; seq is never issued by this master
  assign ap_valid = hsel && hready && (htrans == `MEAR_HTRANS_NONSEQ);
  assign ap_write = hwrite;
  assign ap_idx   = haddr[9:2];
  assign dp_wr    = st_r.wr;
  assign dp_idx   = st_r.idx;

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.wr  = ap_valid && ap_write;
    if (ap_valid)
    begin
      st_nxt.idx = ap_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** hw/mear_regs.sv ***
`timescale 1ns/1ps
`include "mear_defines.svh"
module mear_regs
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire mear_pkg::mear_eng_in_t eng_in,
  output mear_pkg::mear_eng_out_t     eng_out,
  output mear_pkg::mear_cfg_t         cfg_out,
  output logic [4:0]                  status_out
);
  import mear_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    mear_cfg_t      cfg;
    logic           refresh;
    logic           new_sample;
    logic           origin;
    logic           noise;
    logic           trans;
    logic [15:0]    sample;
    logic [15:0]    prev_sample;
    logic           prev_valid;
    logic [15:0]    dc_level;
    logic [15:0]    proc_rate;
    mear_refill_e_t refill;
    mear_eng_out_t  eout;
    logic [31:0]    rdata;
    logic           ready;
    logic           resp;
  } mear_regs_t;

  mear_regs_t  st_r;
  mear_regs_t  st_nxt;

  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_idx;
  logic        dp_wr;
  logic [7:0]  dp_idx;
  logic        recalc;
  logic        hist_restart;
  logic [7:0]  wbyte;
  logic [15:0] slope;

  // ----------------------------------------------------------------
  // bus front and window counter
  // ----------------------------------------------------------------
  mear_ahb_front u_front
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hready   (hready),
    .ap_valid (ap_valid),
    .ap_write (ap_write),
    .ap_idx   (ap_idx),
    .dp_wr    (dp_wr),
    .dp_idx   (dp_idx)
  );

  mear_window_ctr u_window
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .sample_valid (eng_in.sample_valid),
    .restart      (hist_restart),
    .rate         (st_r.cfg.update_rate),
    .recalc       (recalc)
  );

  assign wbyte        = hwdata[7:0];
  // writing one to refresh drops the window history at once
  assign hist_restart = dp_wr && (dp_idx == `MEAR_IDX_ASC0)
                        && wbyte[`MEAR_ASC0_REFRESH]; // [RULE_05]

  assign hrdata     = st_r.rdata;
  assign hreadyout  = st_r.ready;
  assign hresp      = st_r.resp;
  assign eng_out    = st_r.eout;
  assign cfg_out    = st_r.cfg;
  assign status_out = {st_r.refresh, st_r.new_sample, st_r.origin, st_r.noise, st_r.trans};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input mear_regs_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `MEAR_IDX_ASC0:      v = {3'h0, s.refresh, s.new_sample, s.origin,
                                s.noise, s.trans}; // [RULE_02] [RULE_25]
      `MEAR_IDX_ASC2:      v = {s.cfg.lock_level, s.cfg.window_size,
                                s.cfg.update_rate}; // [RULE_03]
      `MEAR_IDX_RATE_HI:   v = s.proc_rate[15:8]; // [RULE_15]
      `MEAR_IDX_RATE_LO:   v = s.proc_rate[7:0]; // [RULE_15]
      `MEAR_IDX_AVG:       v = s.cfg.sample_averaging; // [RULE_16]
      `MEAR_IDX_DEB_TIME:  v = s.cfg.debounce_time; // [RULE_17]
      `MEAR_IDX_DEB_MASK:  v = s.cfg.debounce_batch_mask; // [RULE_18]
      `MEAR_IDX_TRANS_SEN: v = {1'b0, s.cfg.transient_sensitivity}; // [RULE_19]
      `MEAR_IDX_NOISE_SEN: v = {1'b0, s.cfg.noise_sensitivity}; // [RULE_20]
      `MEAR_IDX_SIG_HI:    v = s.sample[15:8]; // [RULE_21]
      `MEAR_IDX_SIG_LO:    v = s.sample[7:0]; // [RULE_21]
      `MEAR_IDX_DC_HI:     v = s.dc_level[15:8]; // [RULE_22]
      `MEAR_IDX_DC_LO:     v = s.dc_level[7:0]; // [RULE_22]
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // slope between successive samples
  // ----------------------------------------------------------------
  assign slope = (eng_in.sample >= st_r.prev_sample)
                 ? (eng_in.sample - st_r.prev_sample)
                 : (st_r.prev_sample - eng_in.sample);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.ready = 1'b1;
    st_nxt.resp  = 1'b0;
    st_nxt.eout  = '0;

    // read data is captured in the address phase so hrdata is a flop;
    // a status set between the two phases shows on the next read
    if (ap_valid && !ap_write)
    begin
      st_nxt.rdata = {24'h000000, rd_byte(st_r, ap_idx)};
    end

    // software writes land in the data phase
    if (dp_wr)
    begin
      case (dp_idx)
        `MEAR_IDX_ASC0:
        begin
          st_nxt.refresh    = wbyte[`MEAR_ASC0_REFRESH]; // [RULE_04]
          st_nxt.new_sample = wbyte[`MEAR_ASC0_NEW];
          st_nxt.noise      = wbyte[`MEAR_ASC0_NOISE];
          st_nxt.trans      = wbyte[`MEAR_ASC0_TRANS];
        end
        `MEAR_IDX_ASC2:
        begin
          st_nxt.cfg.lock_level  = wbyte[`MEAR_ASC2_LOCK_MSB:`MEAR_ASC2_LOCK_LSB]; // [RULE_12]
          st_nxt.cfg.window_size = wbyte[`MEAR_ASC2_SIZE_MSB:`MEAR_ASC2_SIZE_LSB]; // [RULE_13]
          st_nxt.cfg.update_rate = wbyte[`MEAR_ASC2_RATE_MSB:`MEAR_ASC2_RATE_LSB]; // [RULE_14]
        end
        `MEAR_IDX_AVG:
        begin
          st_nxt.cfg.sample_averaging = wbyte; // [RULE_16]
        end
        `MEAR_IDX_DEB_TIME:
        begin
          st_nxt.cfg.debounce_time = wbyte; // [RULE_17]
        end
        `MEAR_IDX_DEB_MASK:
        begin
          st_nxt.cfg.debounce_batch_mask = wbyte; // [RULE_18]
        end
        `MEAR_IDX_TRANS_SEN:
        begin
          st_nxt.cfg.transient_sensitivity = wbyte[`MEAR_SENS_MSB:0]; // [RULE_19]
        end
        `MEAR_IDX_NOISE_SEN:
        begin
          st_nxt.cfg.noise_sensitivity = wbyte[`MEAR_SENS_MSB:0]; // [RULE_20]
        end
        default:
        begin
          st_nxt.rdata = st_nxt.rdata;
        end
      endcase
    end

    // refresh write: refill and forget history
    if (hist_restart)
    begin
      st_nxt.eout.refill_start  = 1'b1; // [RULE_04]
      st_nxt.eout.history_clear = 1'b1; // [RULE_05]
      st_nxt.prev_valid         = 1'b0; // [RULE_05]
      st_nxt.prev_sample        = `MEAR_RST_WORD;
    end

    // refill sequencer: busy until the first fresh limit set
    case (st_r.refill)
      MEAR_REF_IDLE:
      begin
        if (hist_restart)
        begin
          st_nxt.refill = MEAR_REF_FILL; // [RULE_04]
        end
      end
      MEAR_REF_FILL:
      begin
        if (hist_restart)
        begin
          st_nxt.refill = MEAR_REF_FILL;
        end
        else if (recalc)
        begin
          st_nxt.refill = MEAR_REF_DONE;
        end
      end
      MEAR_REF_DONE:
      begin
        st_nxt.refill = hist_restart ? MEAR_REF_FILL : MEAR_REF_IDLE;
      end
      default:
      begin
        st_nxt.refill = MEAR_REF_IDLE;
      end
    endcase
    st_nxt.eout.refill_busy = (st_nxt.refill == MEAR_REF_FILL);

    // new sample: word and flag together, set beats a clear
    if (eng_in.sample_valid)
    begin
      st_nxt.sample     = eng_in.sample; // [RULE_21] [RULE_23]
      st_nxt.new_sample = 1'b1; // [RULE_06] [RULE_23]
      if (!hist_restart)
      begin
        st_nxt.prev_sample       = eng_in.sample;
        st_nxt.prev_valid        = 1'b1;
        // no slope judgement on the first sample after a refill
        st_nxt.eout.slope_accept = st_r.prev_valid
                                   && (slope >= {13'h0000, st_r.cfg.lock_level}); // [RULE_12]
      end
    end

    // motion origin follows every motion event
    if (eng_in.motion_event)
    begin
      st_nxt.origin = eng_in.motion_extended; // [RULE_08]
    end

    // sticky noise and transient, hardware set wins
    if (eng_in.noise_event)
    begin
      st_nxt.noise = 1'b1; // [RULE_09] [RULE_11]
    end
    if (eng_in.transient_event)
    begin
      st_nxt.trans = 1'b1; // [RULE_10] [RULE_11]
    end

    // limit recalculation also publishes the dc level
    if (recalc)
    begin
      st_nxt.eout.limit_recalc = 1'b1; // [RULE_14]
      st_nxt.dc_level          = eng_in.dc_level; // [RULE_22]
    end

    st_nxt.proc_rate = eng_in.process_rate; // [RULE_15]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // zero is a hardware safety value only; no defaults are loaded [RULE_01]
      st_r             <= '0;
      st_r.refill      <= MEAR_REF_IDLE;
      st_r.ready       <= 1'b1;
      st_r.sample      <= `MEAR_RST_WORD;
      st_r.dc_level    <= `MEAR_RST_WORD;
      st_r.prev_sample <= `MEAR_RST_WORD;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** hw/mear_window_ctr.sv ***
`timescale 1ns/1ps
`include "mear_defines.svh"
module mear_window_ctr
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       sample_valid,
  input  wire logic       restart,
  input  wire logic [2:0] rate,
  output logic            recalc
);
  import mear_pkg::*;

  typedef struct packed
  {
    logic [4:0] cnt;
    logic       recalc;
  } mear_win_t;

  mear_win_t  st_r;
  mear_win_t  st_nxt;
  logic [4:0] period;

  // ----------------------------------------------------------------
  // sample counter
  // ----------------------------------------------------------------
  assign period = `MEAR_WIN_BASE + (`MEAR_WIN_STEP * {2'h0, rate}); // [RULE_14]
  assign recalc = st_r.recalc;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.recalc = 1'b0;
    if (restart)
    begin
      st_nxt.cnt = 5'h00;
    end
    else if (sample_valid)
    begin
      // rate change mid-window takes effect at the next compare
      if (st_r.cnt >= period - 5'h01) // [RULE_14]
      begin
        st_nxt.cnt    = 5'h00;
        st_nxt.recalc = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** include/mear_defines.svh ***
`ifndef MEAR_DEFINES_SVH
`define MEAR_DEFINES_SVH
// Overview of operation
// RULE_01: engine itself never initialises configuration registers
// RULE_02: first status/control register at offset F0h
// RULE_03: second status/control register at offset F2h
// RULE_04: refresh bit 4 starts fast buffer refill
// RULE_05: refresh discards accumulated motion detection history
// RULE_06: new-sample flag bit 3 set per sample
// RULE_07: application clears new-sample flag after reading
// RULE_08: origin bit 2 written with each motion event
// RULE_09: noise flag bit 1 set on noise
// RULE_10: transient flag bit 0 set on transient
// RULE_11: application clears noise and transient flags
// RULE_12: lock level bits 7-5 set slope minimum
// RULE_13: window size bits 4-3 select window
// RULE_14: limits recalculated every 4+2*rate samples
// RULE_15: read-only process rate at F3h/F4h
// RULE_16: F5h controls sample averaging amount
// RULE_17: F6h sets motion debounce time
// RULE_18: F7h sets out-of-window samples for debounce
// RULE_19: F8h sets transient detection sensitivity
// RULE_20: F9h sets noise detection sensitivity
// RULE_21: read-only latest signal sample at FAh/FBh
// RULE_22: read-only DC offset at FCh/FDh
// RULE_23: sample stored together with new-sample flag
// RULE_24: application reads 16-bit pairs atomically
// RULE_25: reserved bits 7-5 of F0h read zero

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define MEAR_IDX_ASC0      8'hF0
`define MEAR_IDX_ASC2      8'hF2
`define MEAR_IDX_RATE_HI   8'hF3
`define MEAR_IDX_RATE_LO   8'hF4
`define MEAR_IDX_AVG       8'hF5
`define MEAR_IDX_DEB_TIME  8'hF6
`define MEAR_IDX_DEB_MASK  8'hF7
`define MEAR_IDX_TRANS_SEN 8'hF8
`define MEAR_IDX_NOISE_SEN 8'hF9
`define MEAR_IDX_SIG_HI    8'hFA
`define MEAR_IDX_SIG_LO    8'hFB
`define MEAR_IDX_DC_HI     8'hFC
`define MEAR_IDX_DC_LO     8'hFD

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MEAR_ASC0_REFRESH  4
`define MEAR_ASC0_NEW      3
`define MEAR_ASC0_ORIGIN   2
`define MEAR_ASC0_NOISE    1
`define MEAR_ASC0_TRANS    0
`define MEAR_ASC2_LOCK_MSB 7
`define MEAR_ASC2_LOCK_LSB 5
`define MEAR_ASC2_SIZE_MSB 4
`define MEAR_ASC2_SIZE_LSB 3
`define MEAR_ASC2_RATE_MSB 2
`define MEAR_ASC2_RATE_LSB 0
`define MEAR_SENS_MSB      6

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define MEAR_RST_BYTE      8'h00
`define MEAR_RST_WORD      16'h0000
`define MEAR_WIN_BASE      5'h04
`define MEAR_WIN_STEP      5'h02
`define MEAR_HTRANS_NONSEQ 2'h2
`endif

// *** include/mear_pkg.sv ***
package mear_pkg;

  typedef enum logic [1:0]
  {
    MEAR_REF_IDLE = 2'h0,
    MEAR_REF_FILL = 2'h1,
    MEAR_REF_DONE = 2'h3
  } mear_refill_e_t;

  typedef struct packed
  {
    logic [2:0] lock_level;
    logic [1:0] window_size;
    logic [2:0] update_rate;
    logic [7:0] sample_averaging;
    logic [7:0] debounce_time;
    logic [7:0] debounce_batch_mask;
    logic [6:0] transient_sensitivity;
    logic [6:0] noise_sensitivity;
  } mear_cfg_t;

  typedef struct packed
  {
    logic        sample_valid;
    logic [15:0] sample;
    logic        motion_event;
    logic        motion_extended;
    logic        noise_event;
    logic        transient_event;
    logic [15:0] process_rate;
    logic [15:0] dc_level;
  } mear_eng_in_t;

  typedef struct packed
  {
    logic refill_start;
    logic refill_busy;
    logic history_clear;
    logic limit_recalc;
    logic slope_accept;
  } mear_eng_out_t;

endpackage

// *** verification/mear_regs_checker.sv ***
`timescale 1ns/1ps
module mear_regs_checker
(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic                    hready,
  input wire logic [31:0]             hwdata,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire mear_pkg::mear_eng_in_t  eng_in,
  input wire mear_pkg::mear_eng_out_t eng_out,
  input wire mear_pkg::mear_cfg_t     cfg_out,
  input wire logic [4:0]              status_out
);
  import mear_pkg::*;
  // ------------------------------------------------------------
  // data-phase tracking
  // ------------------------------------------------------------
  logic       wr_r;
  logic [7:0] idx_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r  <= 1'b0;
      idx_r <= 8'h00;
    end
    else
    begin
      wr_r  <= hsel && hready && (htrans == 2'h2) && hwrite;
      idx_r <= haddr[9:2];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  new_flag_set_a: assert property (eng_in.sample_valid |=> status_out[3])
    else $error("new-sample flag not set");
  origin_copy_a: assert property (eng_in.motion_event |=>
    status_out[2] == $past(eng_in.motion_extended))
    else $error("origin flag wrong");
  noise_set_a: assert property (eng_in.noise_event |=> status_out[1])
    else $error("noise flag not set");
  trans_set_a: assert property (eng_in.transient_event |=> status_out[0])
    else $error("transient flag not set");
  // only a software write to the status word may drop a flag other than origin (bit 2)
  flag_hold_a: assert property (!(wr_r && idx_r == 8'hF0) |=>
    ($past(status_out) & 5'h1B & ~status_out) == 5'h00)
    else $error("flag dropped without write");
  cfg_store_a: assert property (wr_r && idx_r == 8'hF2 |=>
    {cfg_out.lock_level, cfg_out.window_size, cfg_out.update_rate} == $past(hwdata[7:0]))
    else $error("window config not stored");
  refill_go_a: assert property (wr_r && idx_r == 8'hF0 && hwdata[4] |->
    ##[1:2] eng_out.refill_start)
    else $error("refill not started");
  history_pair_a: assert property (eng_out.refill_start |->
    eng_out.history_clear ##1 !eng_out.refill_start)
    else $error("history clear not paired");

  cover property (eng_out.limit_recalc);
  cover property (eng_out.refill_start);
  cover property (eng_out.slope_accept);
endmodule

bind mear_regs mear_regs_checker u_chk
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .eng_in(eng_in), .eng_out(eng_out),
  .cfg_out(cfg_out), .status_out(status_out)
);

// *** verification/mear_regs_tb.sv ***
`timescale 1ns/1ps
module mear_regs_tb;
  import mear_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic          hready;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  mear_eng_in_t  ein;
  mear_eng_out_t eout;
  mear_cfg_t     cfg;
  logic [4:0]    stat;
  int            failures;
  int            tests_run;
  int            cyc;
  int            n_rc;
  int            n_rf;
  int            n_sl;

  mear_regs dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .eng_in(ein), .eng_out(eout),
    .cfg_out(cfg), .status_out(stat)
  );
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // idle cycle first: a read right behind a write must not miss it
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), hrdata, {24'h0, e});
  endtask

  task automatic eng(input logic [3:0] ev, input logic ext, input logic [15:0] s);
    @(posedge hclk);
    {ein.sample_valid, ein.motion_event, ein.noise_event, ein.transient_event} <= ev;
    ein.motion_extended <= ext;
    ein.sample          <= s;
    @(posedge hclk);
    {ein.sample_valid, ein.motion_event, ein.noise_event, ein.transient_event} <= 4'h0;
  endtask

  // ------------------------------------------------------------
  // event counters and hang guard
  // ------------------------------------------------------------
  always @(posedge hclk)
  begin
    cyc++;
    n_rc += int'(eout.limit_recalc === 1'b1);
    n_rf += int'(eout.refill_start === 1'b1 && eout.history_clear === 1'b1);
    n_sl += int'(eout.slope_accept === 1'b1);
    if (cyc > 20000)
    begin
      failures++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] ids [15];
    int         b;
    ids = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7,
            8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE};
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    ein   = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ids[i]) rd(ids[i], 8'h00);
    // config words keep A5, sensitivities drop bit 7, read-only and holes stay 0
    foreach (ids[i])
    begin
      if (ids[i] == 8'hF0)
        continue;
      bus(1'b1, ids[i], 8'hA5);
      rd(ids[i], (ids[i] inside {8'hF2, [8'hF5:8'hF7]}) ? 8'hA5 :
                 (ids[i] inside {8'hF8, 8'hF9}) ? 8'h25 : 8'h00);
    end
    chk("avg", cfg.sample_averaging, 8'hA5);
    chk("deb", cfg.debounce_time, 8'hA5);
    chk("mask", cfg.debounce_batch_mask, 8'hA5);
    chk("tsen", cfg.transient_sensitivity, 7'h25);
    chk("nsen", cfg.noise_sensitivity, 7'h25);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'hF2, {3'h5, c[1:0], 3'h2});
      @(posedge hclk);
      chk("wsize", cfg.window_size, c[1:0]);
      chk("lock", cfg.lock_level, 3'h5);
      rd(8'hF2, {3'h5, c[1:0], 3'h2});
    end
    ein.process_rate <= 16'hBEEF;
    rd(8'hF3, 8'hBE);
    rd(8'hF4, 8'hEF);
    bus(1'b1, 8'hF0, 8'hFF);
    rd(8'hF0, 8'h1B);
    bus(1'b1, 8'hF0, 8'h00);
    eng(4'h8, 1'b0, 16'h1234);
    rd(8'hF0, 8'h08);
    rd(8'hFA, 8'h12);
    rd(8'hFB, 8'h34);
    rd(8'hF0, 8'h08);
    bus(1'b1, 8'hF0, 8'h00);
    rd(8'hF0, 8'h00);
    eng(4'h4, 1'b1, 16'h0);
    rd(8'hF0, 8'h04);
    eng(4'h4, 1'b0, 16'h0);
    eng(4'h2, 1'b0, 16'h0);
    rd(8'hF0, 8'h02);
    eng(4'h1, 1'b0, 16'h0);
    rd(8'hF0, 8'h03);
    bus(1'b1, 8'hF0, 8'h00);
    rd(8'hF0, 8'h00);
    // every update rate: recalc exactly on sample 4+2r after a refill
    for (int r = 0; r < 8; r++)
    begin
      bus(1'b1, 8'hF2, {5'h01, r[2:0]});
      ein.dc_level <= 16'h0F00 + 16'(r);
      b = n_rf;
      bus(1'b1, 8'hF0, 8'h10);
      repeat (3) @(posedge hclk);
      chk("refill", n_rf - b, 1);
      chk("busy", eout.refill_busy, 1'b1);
      b = n_rc;
      repeat (3 + 2 * r) eng(4'h8, 1'b0, 16'h0);
      repeat (4) @(posedge hclk);
      chk("early recalc", n_rc - b, 0);
      eng(4'h8, 1'b0, 16'h0);
      repeat (4) @(posedge hclk);
      chk("recalc", n_rc - b, 1);
      chk("busy end", eout.refill_busy, 1'b0);
      rd(8'hFC, 8'h0F);
      rd(8'hFD, 8'(r));
    end
    // slope step below the lock level is ignored, at the level accepted
    bus(1'b1, 8'hF2, 8'h68);
    bus(1'b1, 8'hF0, 8'h10);
    repeat (3) @(posedge hclk);
    b = n_sl;
    eng(4'h8, 1'b0, 16'h0064);
    eng(4'h8, 1'b0, 16'h0066);
    repeat (3) @(posedge hclk);
    chk("no slope", n_sl - b, 0);
    eng(4'h8, 1'b0, 16'h0069);
    repeat (3) @(posedge hclk);
    chk("slope", n_sl - b, 1);
    test_done();
  end
endmodule
